// ---- core/gsc_pkg.sv ----
package gsc_pkg;
  // timing, in own units
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned DEB_MS     = 10;
  localparam int unsigned SPLASH_S   = 5;
  localparam int unsigned AS_DELAY_S = 5;
  localparam int unsigned BYE_S      = 3;
  localparam logic [7:0]  SPLASH_T   = 8'(SPLASH_S);
  localparam logic [7:0]  BYE_T      = 8'(BYE_S);

  // value limits of the set-up items
  localparam logic [7:0]  BL_MAX  = 8'h09;
  localparam logic [7:0]  BYTE_MAX = 8'hFF;
  localparam logic [7:0]  FLAG_MAX = 8'h01;
  localparam logic [7:0]  GT_MAX  = 8'h0F;

  // register byte offsets
  localparam logic [4:0]  A_STATUS = 5'h00;
  localparam logic [4:0]  A_COOL   = 5'h04;
  localparam logic [4:0]  A_HOT    = 5'h08;
  localparam logic [4:0]  A_PASS   = 5'h0C;
  localparam logic [4:0]  A_CFG    = 5'h10;

  // reset values
  localparam logic [7:0]  COOL_RST = 8'h3C;
  localparam logic [7:0]  HOT_RST  = 8'h78;
  localparam logic [15:0] PASS_RST = 16'h0000;

  typedef enum logic [3:0] {
    S_OFF, S_SPLASH, S_STBY, S_START, S_RUN, S_STOP, S_COOL,
    S_SETUP, S_SUB, S_ACK, S_BYE
  } gsc_state_t;

  typedef enum logic [3:0] {
    ST_OFF, ST_SPLASH, ST_STBY, ST_AUTO, ST_START, ST_RUN, ST_STOP,
    ST_COOL, ST_SETUP, ST_SUB, ST_AS_ON, ST_AS_OFF, ST_BYE
  } gsc_stat_t;

  typedef enum logic [1:0] {SPD_STOP, SPD_IDLE, SPD_NORM, SPD_MAX} gsc_spd_t;

  typedef enum logic [3:0] {
    M_BL1, M_BL2, M_DIM, M_CFG, M_NET, M_SAVE, M_AS, M_SERV, M_PRIME, M_DEG
  } gsc_item_t;

  typedef struct packed {
    logic [3:0] bl_norm;
    logic [3:0] bl_dim;
    logic [7:0] dim_time;
    logic [7:0] panel_bus_identifier;
    logic [3:0] gen_type;
    logic       autostart;
  } gsc_cfg_t;

  typedef struct packed {
    logic onoff;
    logic startstop;
    logic up;
    logic down;
    logic remote_start_input;
    logic clutch;
    logic eng_run;
  } gsc_in_t;

  typedef struct packed {
    gsc_spd_t speed;
    logic     run;
    logic     conv_en;
  } gsc_eng_t;

  typedef struct packed {
    logic [15:0] rsv;
    logic [7:0]  countdown;
    logic [1:0]  rsv2;
    logic        dimmed;
    logic        as_active;
    gsc_stat_t   stat;
  } gsc_status_t;
endpackage

// ---- core/gsc_ctrl.sv ----
// How it works
// [R1] clutch engaged: engine commanded to maximum speed
// [R2] clutch released: speed back to normal
// [R3] stop press when running: stopping, then stand-by
// [R4] hot head on stop: cool-down timer, countdown
// [R5] cool-down: converter off, engine at idle
// [R6] cool-down ignores remote start requests
// [R7] cool-down expiry stops engine automatically
// [R8] stop press during cool-down stops at once
// [R9] manual start/stop under autostart drops autostart
// [R10] remote asserted 5 s: autostart starts generator
// [R11] remote released 5 s: autostart stops generator
// [R12] status shows autostart instead of stand-by
// [R13] autostart flag kept in nonvolatile memory
// [R14] set-up entered by down during splash
// [R15] cursors move item, start/stop opens it
// [R16] normal and dimmed backlight, 0 to 9
// [R17] dim after idle dim time, 0 disables
// [R18] save writes settings, goodbye 3 s, off
// [R19] saved values apply at next power-up
// [R20] config changes need the password
// [R21] autostart sub-menu toggles, confirms, acknowledges
// [R22] after power-on: stand-by, start or off
// [R23] hot limit and cool-down length stored
// [R24] inputs debounced, one event per press
`timescale 1ns/100ps
module gsc_ctrl #(
  parameter int unsigned SEC_CYC  = gsc_pkg::CLK_HZ,
  parameter int unsigned DEB_CYC  = gsc_pkg::CLK_HZ / 1000 * gsc_pkg::DEB_MS,
  parameter int unsigned AS_CYC   = SEC_CYC * gsc_pkg::AS_DELAY_S,
  parameter logic [15:0] CFG_PASS = 16'hA5C3 // arbitrary value
) (
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // panel pins and sensors
  input  wire gsc_pkg::gsc_in_t  pins,
  input  wire logic [7:0]        cht_temp,
  // nonvolatile settings store
  input  wire gsc_pkg::gsc_cfg_t nvm_rdata,
  output logic                   nvm_wr,
  output gsc_pkg::gsc_cfg_t      nvm_wdata,
  // engine, display, power
  output gsc_pkg::gsc_eng_t      eng,
  output gsc_pkg::gsc_stat_t     status,
  output logic [7:0]             countdown,
  output logic [3:0]             backlight,
  output logic                   power_en
);
  localparam int unsigned NIN = $bits(gsc_pkg::gsc_in_t);

  gsc_pkg::gsc_state_t state_r;
  gsc_pkg::gsc_item_t  menu_r;
  gsc_pkg::gsc_cfg_t   act_r, edit_r;
  gsc_pkg::gsc_in_t    lvl, ev;
  logic [NIN-1:0]      s1_r, s2_r, deb_r, debq_r;
  logic [31:0]         dcnt_r [NIN];
  logic [31:0]         pre_r, as_cnt_r;
  logic [7:0]          tmr_r, sub_r, dim_cnt_r, cool_r, hot_r;
  logic [15:0]         pass_r;
  logic                sec_tick, tmr_done, manual_r, as_active_r;
  logic                rem_seen_r, as_fire, as_start, as_stop, pw_ok;
  logic                dimmed, stop_req, ap_we_r, any_btn;
  logic [4:0]          ap_addr_r;

  function automatic logic [7:0] item_lim(gsc_pkg::gsc_item_t m,
                                          logic unlocked);
    case (m)
      gsc_pkg::M_BL1, gsc_pkg::M_BL2: item_lim = gsc_pkg::BL_MAX;
      gsc_pkg::M_DIM, gsc_pkg::M_NET: item_lim = gsc_pkg::BYTE_MAX;
      gsc_pkg::M_AS:  item_lim = gsc_pkg::FLAG_MAX;
      gsc_pkg::M_CFG: item_lim = unlocked ? gsc_pkg::GT_MAX : 8'h00;
      default:        item_lim = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] item_val(gsc_pkg::gsc_cfg_t c,
                                          gsc_pkg::gsc_item_t m);
    case (m)
      gsc_pkg::M_BL1: item_val = {4'h0, c.bl_norm};
      gsc_pkg::M_BL2: item_val = {4'h0, c.bl_dim};
      gsc_pkg::M_DIM: item_val = c.dim_time;
      gsc_pkg::M_NET: item_val = c.panel_bus_identifier;
      gsc_pkg::M_CFG: item_val = {4'h0, c.gen_type};
      gsc_pkg::M_AS:  item_val = {7'h00, c.autostart};
      default:        item_val = 8'h00;
    endcase
  endfunction

  // two-flop sync, then a stable-count filter per pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (ce) begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deb_r  <= '0;
      debq_r <= '0;
      for (int i = 0; i < NIN; i++) dcnt_r[i] <= '0;
    end else if (ce) begin
      debq_r <= deb_r;
      for (int i = 0; i < NIN; i++) begin
        if (s2_r[i] == deb_r[i]) begin
          dcnt_r[i] <= '0;
        end else if (dcnt_r[i] == 32'(DEB_CYC - 1)) begin
          deb_r[i]  <= s2_r[i];  // [R24]
          dcnt_r[i] <= '0;
        end else begin
          dcnt_r[i] <= dcnt_r[i] + 32'h1;
        end
      end
    end
  end

  assign lvl     = deb_r;
  assign ev      = ce ? (deb_r & ~debq_r) : '0;  // [R24]
  assign any_btn = ev.onoff | ev.startstop | ev.up | ev.down;

  // remote contact must hold its new level for the full delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_seen_r  <= 1'b0;
      as_cnt_r    <= '0;
      as_active_r <= 1'b0;
    end else if (ce) begin
      if (lvl.remote_start_input == rem_seen_r) begin
        as_cnt_r <= '0;
      end else if (as_cnt_r == 32'(AS_CYC - 1)) begin
        rem_seen_r <= lvl.remote_start_input;
        as_cnt_r   <= '0;
      end else begin
        as_cnt_r <= as_cnt_r + 32'h1;
      end
      if (state_r == gsc_pkg::S_OFF && ev.onoff)
        as_active_r <= nvm_rdata.autostart;  // [R13]
      else if (state_r == gsc_pkg::S_STOP && !lvl.eng_run && manual_r)
        as_active_r <= 1'b0;  // [R9]
    end
  end

  assign as_fire  = ce && lvl.remote_start_input != rem_seen_r
                    && as_cnt_r == 32'(AS_CYC - 1);
  assign as_start = as_fire && lvl.remote_start_input && as_active_r;
  assign as_stop  = as_fire && !lvl.remote_start_input && as_active_r;
  assign sec_tick = pre_r == 32'(SEC_CYC - 1);
  assign tmr_done = sec_tick && tmr_r <= 8'h01;
  assign pw_ok    = pass_r == CFG_PASS;
  assign stop_req = ev.startstop || (as_stop && !manual_r);

  // operating sequence; timer loads restart the second prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= gsc_pkg::S_OFF;
      tmr_r    <= '0;
      pre_r    <= '0;
      manual_r <= 1'b0;
    end else if (ce) begin
      pre_r <= sec_tick ? '0 : pre_r + 32'h1;
      if (sec_tick && tmr_r != 8'h00) tmr_r <= tmr_r - 8'h01;
      case (state_r)
        gsc_pkg::S_OFF: if (ev.onoff) begin
          state_r <= gsc_pkg::S_SPLASH;
          tmr_r   <= gsc_pkg::SPLASH_T;
          pre_r   <= '0;
        end
        gsc_pkg::S_SPLASH: begin
          if (ev.down) state_r <= gsc_pkg::S_SETUP;  // [R14]
          else if (tmr_done) state_r <= gsc_pkg::S_STBY;  // [R22]
        end
        gsc_pkg::S_STBY: begin
          if (ev.onoff) begin
            state_r <= gsc_pkg::S_OFF;  // [R22]
          end else if (ev.startstop) begin
            state_r  <= gsc_pkg::S_START;  // [R22]
            manual_r <= 1'b1;
          end else if (as_start) begin
            state_r  <= gsc_pkg::S_START;  // [R10]
            manual_r <= 1'b0;
          end
        end
        gsc_pkg::S_START: begin
          if (ev.startstop) state_r <= gsc_pkg::S_STOP;
          else if (lvl.eng_run) state_r <= gsc_pkg::S_RUN;
        end
        gsc_pkg::S_RUN: if (stop_req) begin  // [R11]
          if (cht_temp >= hot_r) begin
            state_r <= gsc_pkg::S_COOL;  // [R4] [R23]
            tmr_r   <= cool_r;
            pre_r   <= '0;
          end else begin
            state_r <= gsc_pkg::S_STOP;  // [R3]
          end
        end
        gsc_pkg::S_COOL: begin
          // remote events are not looked at here
          if (ev.startstop) state_r <= gsc_pkg::S_STOP;  // [R8] [R6]
          else if (tmr_r == 8'h00 || tmr_done)
            state_r <= gsc_pkg::S_STOP;  // [R7]
        end
        gsc_pkg::S_STOP: if (!lvl.eng_run) begin
          state_r  <= gsc_pkg::S_STBY;  // [R3]
          manual_r <= 1'b0;
        end
        gsc_pkg::S_SETUP: if (ev.startstop) begin
          case (menu_r)
            gsc_pkg::M_SAVE: begin
              state_r <= gsc_pkg::S_BYE;  // [R18]
              tmr_r   <= gsc_pkg::BYE_T;
              pre_r   <= '0;
            end
            gsc_pkg::M_BL1, gsc_pkg::M_BL2, gsc_pkg::M_DIM,
            gsc_pkg::M_CFG, gsc_pkg::M_NET, gsc_pkg::M_AS:
              state_r <= gsc_pkg::S_SUB;  // [R15]
            default: state_r <= gsc_pkg::S_SETUP;
          endcase
        end
        gsc_pkg::S_SUB: if (ev.startstop) begin
          if (menu_r == gsc_pkg::M_AS) begin
            state_r <= gsc_pkg::S_ACK;  // [R21]
            tmr_r   <= gsc_pkg::BYE_T;
            pre_r   <= '0;
          end else begin
            state_r <= gsc_pkg::S_SETUP;
          end
        end
        gsc_pkg::S_ACK: if (tmr_done) begin
          state_r <= gsc_pkg::S_BYE;
          tmr_r   <= gsc_pkg::BYE_T;
          pre_r   <= '0;
        end
        gsc_pkg::S_BYE: if (tmr_done) state_r <= gsc_pkg::S_OFF;  // [R18]
        default: state_r <= gsc_pkg::S_OFF;
      endcase
    end
  end

  // set-up menu; edits stay apart from the applied copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      menu_r    <= gsc_pkg::M_BL1;
      sub_r     <= '0;
      edit_r    <= '0;
      act_r     <= '0;
      nvm_wr    <= 1'b0;
      nvm_wdata <= '0;
    end else if (ce) begin
      nvm_wr <= 1'b0;
      if (state_r == gsc_pkg::S_OFF && ev.onoff) begin
        act_r  <= nvm_rdata;  // [R19]
        edit_r <= nvm_rdata;
        menu_r <= gsc_pkg::M_BL1;
      end
      if (state_r == gsc_pkg::S_SETUP) begin
        if (ev.up)  // [R15]
          menu_r <= menu_r == gsc_pkg::M_BL1 ? gsc_pkg::M_DEG
                    : gsc_pkg::gsc_item_t'(menu_r - 4'h1);
        else if (ev.down)
          menu_r <= menu_r == gsc_pkg::M_DEG ? gsc_pkg::M_BL1
                    : gsc_pkg::gsc_item_t'(menu_r + 4'h1);
        else if (ev.startstop)
          sub_r <= item_val(edit_r, menu_r);
        if (ev.startstop && menu_r == gsc_pkg::M_SAVE) begin
          nvm_wr    <= 1'b1;  // [R18]
          nvm_wdata <= edit_r;
        end
      end
      if (state_r == gsc_pkg::S_SUB) begin
        if (ev.up && sub_r < item_lim(menu_r, pw_ok))
          sub_r <= sub_r + 8'h01;  // [R16] [R17] [R21]
        else if (ev.down && sub_r != 8'h00 &&
                 item_lim(menu_r, pw_ok) != 8'h00)
          sub_r <= sub_r - 8'h01;  // [R20]
        else if (ev.startstop) begin
          case (menu_r)
            gsc_pkg::M_BL1: edit_r.bl_norm  <= sub_r[3:0];  // [R16]
            gsc_pkg::M_BL2: edit_r.bl_dim   <= sub_r[3:0];
            gsc_pkg::M_DIM: edit_r.dim_time <= sub_r;  // [R17]
            gsc_pkg::M_NET: edit_r.panel_bus_identifier <= sub_r;
            gsc_pkg::M_CFG:
              if (pw_ok) edit_r.gen_type <= sub_r[3:0];  // [R20]
            gsc_pkg::M_AS: begin
              edit_r.autostart    <= sub_r[0];  // [R13]
              nvm_wr              <= 1'b1;
              nvm_wdata           <= edit_r;
              nvm_wdata.autostart <= sub_r[0];
            end
            default: edit_r <= edit_r;
          endcase
        end
      end
    end
  end

  // backlight dimming from the values applied at power-up
  assign dimmed = act_r.dim_time != 8'h00 && dim_cnt_r >= act_r.dim_time;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dim_cnt_r <= '0;
      backlight <= '0;
    end else if (ce) begin
      if (any_btn) dim_cnt_r <= '0;
      else if (sec_tick && dim_cnt_r != gsc_pkg::BYTE_MAX)
        dim_cnt_r <= dim_cnt_r + 8'h01;
      if (state_r == gsc_pkg::S_OFF) backlight <= '0;
      else backlight <= dimmed ? act_r.bl_dim : act_r.bl_norm;  // [R17]
    end
  end

  // registered engine, display and power outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng       <= '0;
      status    <= gsc_pkg::ST_OFF;
      countdown <= '0;
      power_en  <= 1'b0;
    end else if (ce) begin
      power_en    <= state_r != gsc_pkg::S_OFF;
      countdown   <= state_r == gsc_pkg::S_COOL ? tmr_r : 8'h00;  // [R4]
      eng.run     <= state_r == gsc_pkg::S_START ||
                     state_r == gsc_pkg::S_RUN || state_r == gsc_pkg::S_COOL;
      eng.conv_en <= state_r == gsc_pkg::S_RUN;  // [R5]
      case (state_r)
        gsc_pkg::S_RUN:
          eng.speed <= lvl.clutch ? gsc_pkg::SPD_MAX  // [R1]
                       : gsc_pkg::SPD_NORM;  // [R2]
        gsc_pkg::S_START: eng.speed <= gsc_pkg::SPD_NORM;
        gsc_pkg::S_COOL:  eng.speed <= gsc_pkg::SPD_IDLE;  // [R5]
        default:          eng.speed <= gsc_pkg::SPD_STOP;
      endcase
      case (state_r)
        gsc_pkg::S_SPLASH: status <= gsc_pkg::ST_SPLASH;
        gsc_pkg::S_STBY:
          status <= as_active_r ? gsc_pkg::ST_AUTO  // [R12]
                    : gsc_pkg::ST_STBY;
        gsc_pkg::S_START: status <= gsc_pkg::ST_START;
        gsc_pkg::S_RUN:   status <= gsc_pkg::ST_RUN;
        gsc_pkg::S_STOP:  status <= gsc_pkg::ST_STOP;  // [R3]
        gsc_pkg::S_COOL:  status <= gsc_pkg::ST_COOL;
        gsc_pkg::S_SETUP: status <= gsc_pkg::ST_SETUP;
        gsc_pkg::S_SUB:   status <= gsc_pkg::ST_SUB;
        gsc_pkg::S_ACK:
          status <= edit_r.autostart ? gsc_pkg::ST_AS_ON  // [R21]
                    : gsc_pkg::ST_AS_OFF;
        gsc_pkg::S_BYE:   status <= gsc_pkg::ST_BYE;
        default:          status <= gsc_pkg::ST_OFF;
      endcase
    end
  end

  // ahb-lite slave, no wait states while enabled
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_we_r   <= 1'b0;
      ap_addr_r <= '0;
      hrdata    <= '0;
      cool_r    <= gsc_pkg::COOL_RST;
      hot_r     <= gsc_pkg::HOT_RST;
      pass_r    <= gsc_pkg::PASS_RST;
    end else if (ce) begin
      if (ap_we_r) begin
        case (ap_addr_r)
          gsc_pkg::A_COOL: cool_r <= hwdata[7:0];  // [R23]
          gsc_pkg::A_HOT:  hot_r  <= hwdata[7:0];  // [R23]
          gsc_pkg::A_PASS: pass_r <= hwdata[15:0];
          default:         cool_r <= cool_r;
        endcase
      end
      ap_we_r <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) ap_addr_r <= haddr[4:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[4:0])
          gsc_pkg::A_STATUS:
            hrdata <= {16'h0000, tmr_r, 2'b00, dimmed, as_active_r,
                       status};
          gsc_pkg::A_COOL: hrdata <= {24'h000000, cool_r};
          gsc_pkg::A_HOT:  hrdata <= {24'h000000, hot_r};
          gsc_pkg::A_PASS: hrdata <= {31'h00000000, pw_ok};
          gsc_pkg::A_CFG:  hrdata <= {3'h0, act_r};
          default:         hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  property p_clutch_max;
    @(posedge hclk) disable iff (!hresetn)
    ce && state_r == gsc_pkg::S_RUN && lvl.clutch
      |=> eng.speed == gsc_pkg::SPD_MAX;
  endproperty
  a_clutch_max: assert property (p_clutch_max) // [R1]
    else $error("clutch without max speed");

  property p_clutch_rel;
    @(posedge hclk) disable iff (!hresetn)
    ce && state_r == gsc_pkg::S_RUN && !lvl.clutch
      |=> eng.speed == gsc_pkg::SPD_NORM;
  endproperty
  a_clutch_rel: assert property (p_clutch_rel) // [R2]
    else $error("speed not normal after clutch");

  property p_stop_cold;
    @(posedge hclk) disable iff (!hresetn)
    state_r == gsc_pkg::S_RUN && ev.startstop && cht_temp < hot_r
      |=> state_r == gsc_pkg::S_STOP ##1 status == gsc_pkg::ST_STOP
          || !ce;
  endproperty
  a_stop_cold: assert property (p_stop_cold) // [R3]
    else $error("cold stop did not stop");

  property p_stop_hot;
    @(posedge hclk) disable iff (!hresetn)
    state_r == gsc_pkg::S_RUN && ev.startstop && cht_temp >= hot_r
      |=> state_r == gsc_pkg::S_COOL && tmr_r == $past(cool_r);
  endproperty
  a_stop_hot: assert property (p_stop_hot) // [R4]
    else $error("hot stop skipped cool-down");

  property p_cool_out;
    @(posedge hclk) disable iff (!hresetn)
    ce && state_r == gsc_pkg::S_COOL
      |=> !eng.conv_en && eng.speed == gsc_pkg::SPD_IDLE && eng.run;
  endproperty
  a_cool_out: assert property (p_cool_out) // [R5]
    else $error("cool-down outputs wrong");

  property p_cool_hold;
    @(posedge hclk) disable iff (!hresetn)
    state_r == gsc_pkg::S_COOL && !ev.startstop && !tmr_done
      && tmr_r != 8'h00 |=> state_r == gsc_pkg::S_COOL;
  endproperty
  a_cool_hold: assert property (p_cool_hold) // [R6]
    else $error("cool-down left early");

  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
    state_r == gsc_pkg::S_COOL && ev.startstop
      |=> state_r == gsc_pkg::S_STOP ##1 !eng.run || !ce;
  endproperty
  a_abort: assert property (p_abort) // [R8]
    else $error("abort did not stop engine");

  property p_setup_entry;
    @(posedge hclk) disable iff (!hresetn)
    $rose(state_r == gsc_pkg::S_SETUP)
      |-> $past(state_r) inside {gsc_pkg::S_SPLASH, gsc_pkg::S_SUB};
  endproperty
  a_setup_entry: assert property (p_setup_entry) // [R14]
    else $error("set-up entered from wrong state");

  property p_bl_range;
    @(posedge hclk) disable iff (!hresetn)
    edit_r.bl_norm <= gsc_pkg::BL_MAX[3:0]
      && edit_r.bl_dim <= gsc_pkg::BL_MAX[3:0];
  endproperty
  a_bl_range: assert property (p_bl_range) // [R16]
    else $error("backlight level above nine");

  property p_save;
    @(posedge hclk) disable iff (!hresetn)
    state_r == gsc_pkg::S_SETUP && ev.startstop
      && menu_r == gsc_pkg::M_SAVE
      |=> nvm_wr && nvm_wdata == $past(edit_r)
          && state_r == gsc_pkg::S_BYE;
  endproperty
  a_save: assert property (p_save) // [R18]
    else $error("save did not write settings");
endmodule

// ---- dv/gsc_engine_model.sv ----
`timescale 1ns/100ps
module gsc_engine_model #(
  parameter int unsigned SPIN = 8
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // engine command and feedback
  input  wire gsc_pkg::gsc_eng_t eng,
  // settings store
  input  wire logic              nvm_wr,
  input  wire gsc_pkg::gsc_cfg_t nvm_wdata,
  output logic                   eng_run,
  output gsc_pkg::gsc_cfg_t      nvm_rdata
);
  int unsigned       cnt_r;
  // store is not cleared by reset: it outlives power cycles
  gsc_pkg::gsc_cfg_t store_r = '0;
  assign nvm_rdata = store_r;
  always @(posedge hclk) if (nvm_wr) store_r <= nvm_wdata;
  // engine needs a few cycles to spin up or run down
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= 0;
      eng_run <= 1'b0;
    end else if (eng.run != eng_run) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == SPIN) eng_run <= eng.run;
    end else cnt_r <= 0;
  end
endmodule

// ---- dv/tb_genset_stop_autostart_setup_ctrl.sv ----
`timescale 1ns/100ps
module tb_genset_stop_autostart_setup_ctrl;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, ce = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v, seed = 32'h47E4;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, nvm_wr, power_en, eng_run;
  logic [7:0] cht = 0, countdown;
  logic [3:0] backlight;
  gsc_pkg::gsc_in_t btn = '0, pins;
  gsc_pkg::gsc_cfg_t nvm_rdata, nvm_wdata;
  gsc_pkg::gsc_eng_t eng;
  gsc_pkg::gsc_stat_t status;
  int n_mismatch = 0, tests_run = 0;
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  always_comb begin
    pins = btn;
    pins.eng_run = eng_run;
  end
  gsc_ctrl #(.SEC_CYC(20), .DEB_CYC(3), .AS_CYC(100)) gsc_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pins(pins), .cht_temp(cht), .nvm_rdata(nvm_rdata), .nvm_wr(nvm_wr),
    .nvm_wdata(nvm_wdata), .eng(eng), .status(status),
    .countdown(countdown), .backlight(backlight), .power_en(power_en));
  gsc_engine_model gsc_engine_model_inst (
    .hclk(hclk), .hresetn(hresetn), .eng(eng), .nvm_wr(nvm_wr),
    .nvm_wdata(nvm_wdata), .eng_run(eng_run), .nvm_rdata(nvm_rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // no wait count assumed: only the watchdog ends a stuck transfer
  task automatic hwait;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hwait();
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask
  task automatic press(input int b);
    btn[b] <= 1'b1;
    repeat (10) @(posedge hclk);
    btn[b] <= 1'b0;
    repeat (10) @(posedge hclk);
  endtask
  task automatic wait_for(input gsc_pkg::gsc_stat_t s, input int lim);
    int n;
    n = 0;
    while (status !== s && n < lim) begin
      n++;
      @(posedge hclk);
    end
    check(status, s);
  endtask
  task automatic cool_entry;
    press(5);
    wait_for(gsc_pkg::ST_COOL, 60);
    check(eng.speed, gsc_pkg::SPD_IDLE);
    check(eng.conv_en, 0);
    check(countdown >= 1 && countdown <= 3, 1);
  endtask
  initial begin
    #(20000 * 50);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    check(status, gsc_pkg::ST_OFF);
    ahb(0, 32'h4, 0);
    check(rd, 32'h3C);
    check(hresp, 0);
    ahb(0, 32'h8, 0);
    check(rd, 32'h78);
    ahb(0, 32'h14, 0);
    check(rd, 0);
    seed = xs(seed);
    ahb(1, 32'h8, seed);
    ahb(0, 32'h8, 0);
    check(rd, {24'h0, seed[7:0]});
    ahb(1, 32'h4, 32'h3);
    ahb(1, 32'h8, 32'h0);
    press(6);
    wait_for(gsc_pkg::ST_STBY, 200);
    check(power_en, 1);
    press(5);
    wait_for(gsc_pkg::ST_RUN, 60);
    check(eng.speed, gsc_pkg::SPD_NORM);
    ce <= 1'b0;
    repeat (5) @(posedge hclk);
    check(hready, 0);
    check(status, gsc_pkg::ST_RUN);
    ce <= 1'b1;
    btn.clutch <= 1'b1;
    repeat (12) @(posedge hclk);
    check(eng.speed, gsc_pkg::SPD_MAX);
    btn.clutch <= 1'b0;
    repeat (12) @(posedge hclk);
    check(eng.speed, gsc_pkg::SPD_NORM);
    cool_entry();
    wait_for(gsc_pkg::ST_STOP, 80);
    wait_for(gsc_pkg::ST_STBY, 60);
    check(eng.run, 0);
    ahb(1, 32'h4, 32'h3);
    press(5);
    wait_for(gsc_pkg::ST_RUN, 60);
    cool_entry();
    press(5);
    wait_for(gsc_pkg::ST_STBY, 40);
    ahb(1, 32'h8, 32'hFF);
    seed = xs(seed);
    cht <= seed[7:0] % 8'hFF;
    press(5);
    wait_for(gsc_pkg::ST_RUN, 60);
    press(5);
    wait_for(gsc_pkg::ST_STOP, 5);
    wait_for(gsc_pkg::ST_STBY, 60);
    press(6);
    wait_for(gsc_pkg::ST_OFF, 5);
    press(6);
    press(3);
    wait_for(gsc_pkg::ST_SETUP, 100);
    repeat (6) press(3);
    press(5);
    wait_for(gsc_pkg::ST_SUB, 5);
    press(4);
    press(5);
    wait_for(gsc_pkg::ST_AS_ON, 5);
    check(nvm_rdata.autostart, 1);
    wait_for(gsc_pkg::ST_BYE, 80);
    wait_for(gsc_pkg::ST_OFF, 80);
    press(6);
    wait_for(gsc_pkg::ST_AUTO, 200);
    btn.remote_start_input <= 1'b1;
    repeat (80) @(posedge hclk);
    check(status, gsc_pkg::ST_AUTO);
    wait_for(gsc_pkg::ST_RUN, 100);
    btn.remote_start_input <= 1'b0;
    repeat (80) @(posedge hclk);
    check(status, gsc_pkg::ST_RUN);
    wait_for(gsc_pkg::ST_AUTO, 150);
    // manual run under autostart falls back to plain stand-by
    press(5);
    wait_for(gsc_pkg::ST_RUN, 60);
    press(5);
    wait_for(gsc_pkg::ST_STBY, 60);
    press(6);
    press(6);
    press(3);
    wait_for(gsc_pkg::ST_SETUP, 100);
    // bl1 to 3, bl2 to 2, dim to 1, locked config tried with 3 ups
    for (int i = 0; i < 4; i++) begin
      press(5);
      repeat (3 - i % 3) press(4);
      press(5);
      press(3);
    end
    press(3);
    press(5);
    wait_for(gsc_pkg::ST_BYE, 5);
    ahb(0, 32'h10, 0);
    check(rd, 32'h1);
    wait_for(gsc_pkg::ST_OFF, 80);
    check(power_en, 0);
    press(6);
    check(backlight, 4'h3);
    repeat (30) @(posedge hclk);
    check(backlight, 4'h2);
    ahb(0, 32'h10, 0);
    check(rd, {3'h0, 4'h3, 4'h2, 8'h01, 8'h00, 4'h0, 1'b1});
    final_report();
  end
endmodule
